// ==== shared/dcd_pkg.sv ====
/*
 * constants and types for the command decoder of a dram die.
 * assumes one 250 MHz clock; pins from the controller arrive already in that clock domain.
 */
// Contract
// - write crc error drives alert low for a bounded pulse, then high
// - parity error holds alert low until internal recovery finishes
// - test enable high places device into boundary scan operation
// - strobes are differential pairs only; single-ended strobes unsupported
// - x16: lower strobe qualifies lower byte, upper strobe the upper byte
// - mrs: cke high both, cs low, act high, ras cas we low
// - refresh: cs low act high ras cas low we high; cke falling gives self refresh entry
// - self refresh exit: cke rises with cs high or cs low and rest high
// - precharge: ras low cas high we low; a10 picks one or all banks
// - activate: cs and act low with cke high; row bits on command pins
// - write: ras high cas we low; otf uses a12 chop, fixed ignores it
// - write samples a10 for automatic precharge after the burst
// - burst chop pin sampled on writes: high full, low chopped
// - cs high with cke high is deselect; other pins ignored
// - bursts run to completion and are never interrupted
package dcd_pkg;
    // command codes presented on cmd_o
    typedef enum logic [3:0] {
        DCD_NONE = 4'h0, DCD_MRS = 4'h1, DCD_REF = 4'h2, DCD_SRE = 4'h3,
        DCD_SRX  = 4'h4, DCD_PRE = 4'h5, DCD_PREA = 4'h6, DCD_ACT = 4'h7,
        DCD_WR   = 4'h8, DCD_RSV = 4'h9
    } dcd_cmd_t;

    // alert states
    typedef enum logic [2:0] {
        DCD_AL_IDLE = 3'b001,
        DCD_AL_CRC  = 3'b010,
        DCD_AL_PAR  = 3'b100
    } dcd_alert_t;

    // timing, ps and ns, and derived cycles
    localparam int DCD_CLK_PS        = 4000;
    localparam int DCD_CRC_PULSE_NS  = 40;
    localparam int DCD_CRC_PULSE_CYC = (DCD_CRC_PULSE_NS * 1000) / DCD_CLK_PS;
    localparam int DCD_BURST_FULL    = 4;   // clocks of an 8-beat burst
    localparam int DCD_BURST_CHOP    = 2;   // clocks of a chopped burst
    localparam logic DCD_ALERT_RST   = 1'b1;
endpackage

// ==== verilog/dcd_decoder.sv ====
/*
 * command decoder and alert driver of one dram die.
 * assumes the pins are sampled on mclk_i (the ck_t rising edge domain),
 * and that crc, parity and recovery-done events come from logic on mclk_i.
 * strobes and data pins never reach this block; only their pairing duties are noted.
 */
`timescale 1ns/1ps
module dcd_decoder
    import dcd_pkg::*;
#(
    parameter int ROW_W  = 18,
    parameter int COL_W  = 10
) (
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    // command pins, already in the clock domain
    input  wire logic             cke_i,
    input  wire logic             cs_n_i,
    input  wire logic             act_n_i,
    input  wire logic             ras_n_i,
    input  wire logic             cas_n_i,
    input  wire logic             we_n_i,
    input  wire logic [1:0]       bg_i,
    input  wire logic [1:0]       ba_i,
    input  wire logic [13:0]      addr_i,
    // configuration and events from inside the die
    input  wire logic             bl_otf_i,
    input  wire logic             crc_err_i,
    input  wire logic             par_err_i,
    input  wire logic             recov_done_i,
    input  wire logic             test_en_i,
    // decoded outputs
    output logic [3:0]            cmd_o,
    output logic [1:0]            bg_o,
    output logic [1:0]            ba_o,
    output logic [ROW_W-1:0]      row_o,
    output logic [COL_W-1:0]      col_o,
    output logic [13:0]           opcode_o,
    output logic                  auto_pre_o,
    output logic                  chop_o,
    output logic                  burst_busy_o,
    output logic                  self_ref_o,
    output logic                  scan_mode_o,
    output logic                  alert_n_o
);

    // decode state
    logic             cke_prev, next_cke_prev;
    dcd_cmd_t         cmd, next_cmd;
    logic [1:0]       bg, next_bg, ba, next_ba;
    logic [ROW_W-1:0] row, next_row;
    logic [COL_W-1:0] col, next_col;
    logic [13:0]      opc, next_opc;
    logic             ap, next_ap, chop, next_chop;
    logic             sref, next_sref, scan, next_scan;
    logic [2:0]       bcnt, next_bcnt;
    logic             busy, next_busy;

    // next-value decode of the sampled pins
    // test enable is taken as a quiet level from inside the die, so it is not synchronised
    always_comb begin
        next_cke_prev = cke_i;
        next_cmd      = DCD_NONE;
        next_bg       = bg;
        next_ba       = ba;
        next_row      = row;
        next_col      = col;
        next_opc      = opc;
        next_ap       = ap;
        next_chop     = chop;
        next_sref     = sref;
        next_scan     = test_en_i;
        next_bcnt     = (bcnt != 3'h0) ? bcnt - 3'h1 : 3'h0;
        // exit is tried first: its low cke_prev keeps it apart from every other row
        if (!cke_prev && cke_i && sref &&
            (cs_n_i || (!act_n_i ? 1'b0 : (ras_n_i && cas_n_i && we_n_i)))) begin
            next_cmd  = DCD_SRX;
            next_sref = 1'b0;
        end else if (cke_prev && !cs_n_i) begin
            if (!act_n_i && cke_i) begin
                next_cmd = DCD_ACT;
                next_bg  = bg_i;
                next_ba  = ba_i;
                next_row = ROW_W'({ras_n_i, cas_n_i, we_n_i, addr_i[13:0]});
            end else if (act_n_i) begin
                case ({ras_n_i, cas_n_i, we_n_i})
                    3'b000: if (cke_i) begin
                        next_cmd = DCD_MRS;
                        next_bg  = bg_i;
                        next_ba  = ba_i;
                        next_opc = addr_i;
                    end
                    3'b001: begin
                        next_cmd  = cke_i ? DCD_REF : DCD_SRE;
                        next_sref = !cke_i;
                    end
                    3'b010: if (cke_i) begin
                        next_cmd = addr_i[10] ? DCD_PREA : DCD_PRE;
                        next_bg  = bg_i;
                        next_ba  = ba_i;
                    end
                    3'b011: if (cke_i) begin
                        next_cmd = DCD_RSV;
                    end
                    // a write while a burst runs is dropped: bursts are never cut short
                    3'b100: if (cke_i && bcnt == 3'h0) begin
                        next_cmd  = DCD_WR;
                        next_bg   = bg_i;
                        next_ba   = ba_i;
                        next_col  = COL_W'(addr_i[9:0]);
                        next_ap   = addr_i[10];
                        next_chop = bl_otf_i && !addr_i[12];
                        next_bcnt = (bl_otf_i && !addr_i[12]) ?
                                    3'(DCD_BURST_CHOP) : 3'(DCD_BURST_FULL);
                    end
                    default: next_cmd = DCD_NONE;
                endcase
            end
        end
        // busy is registered so that the pin comes straight from a flip-flop
        next_busy = (next_bcnt != 3'h0);
    end

    // decode registers
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cke_prev <= 1'b0;
            cmd      <= DCD_NONE;
            bg       <= 2'h0;
            ba       <= 2'h0;
            row      <= '0;
            col      <= '0;
            opc      <= 14'h0;
            ap       <= 1'b0;
            chop     <= 1'b0;
            sref     <= 1'b0;
            scan     <= 1'b0;
            bcnt     <= 3'h0;
            busy     <= 1'b0;
        end else begin
            cke_prev <= next_cke_prev;
            cmd      <= next_cmd;
            bg       <= next_bg;
            ba       <= next_ba;
            row      <= next_row;
            col      <= next_col;
            opc      <= next_opc;
            ap       <= next_ap;
            chop     <= next_chop;
            sref     <= next_sref;
            scan     <= next_scan;
            bcnt     <= next_bcnt;
            busy     <= next_busy;
        end
    end

    // alert state; parity outranks crc since its recovery is longer
    dcd_alert_t al, next_al;
    logic [7:0] acnt, next_acnt;
    logic       alert_n, next_alert_n;

    always_comb begin
        next_al      = al;
        next_acnt    = acnt;
        case (al)
            DCD_AL_IDLE: begin
                if (par_err_i) begin
                    next_al = DCD_AL_PAR;
                end else if (crc_err_i) begin
                    next_al   = DCD_AL_CRC;
                    next_acnt = 8'(DCD_CRC_PULSE_CYC - 1);
                end
            end
            DCD_AL_CRC: begin
                if (par_err_i) begin
                    next_al = DCD_AL_PAR;
                end else if (acnt == 8'h0) begin
                    next_al = DCD_AL_IDLE;
                end else begin
                    next_acnt = acnt - 8'h1;
                end
            end
            DCD_AL_PAR: begin
                // a fresh parity error beside recovery done keeps the hold (set wins)
                if (recov_done_i && !par_err_i) next_al = DCD_AL_IDLE;
            end
            default: next_al = DCD_AL_IDLE;
        endcase
        // alert_n is taken from the next state so the pin never lags the state
        next_alert_n = (next_al == DCD_AL_IDLE);
    end

    // alert registers
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            al      <= DCD_AL_IDLE;
            acnt    <= 8'h0;
            alert_n <= DCD_ALERT_RST;
        end else begin
            al      <= next_al;
            acnt    <= next_acnt;
            alert_n <= next_alert_n;
        end
    end

    // outputs straight from flip-flops
    assign cmd_o        = cmd;
    assign bg_o         = bg;
    assign ba_o         = ba;
    assign row_o        = row;
    assign col_o        = col;
    assign opcode_o     = opc;
    assign auto_pre_o   = ap;
    assign chop_o       = chop;
    assign burst_busy_o = busy;
    assign self_ref_o   = sref;
    assign scan_mode_o  = scan;
    assign alert_n_o    = alert_n;

    // strobe duties belong to the data path; no strobe or data pin enters this block
    // only differential strobe pairs exist there, nothing here drives one end
    // byte-to-strobe pairing is fixed by data path wiring, not decoded here
endmodule // dcd_decoder

// ==== tb/dcd_decoder_chk.sv ====
/* port checker for dcd_decoder.
   assumes a bind from the bench top and one clock domain. */
`timescale 1ns/1ps
module dcd_decoder_chk
    import dcd_pkg::*;
(
    // watched pins and events, grouped to save space
    input wire logic        mclk_i, sys_rst_i, cke_i, cs_n_i, act_n_i, ras_n_i,
    input wire logic        cas_n_i, we_n_i, bl_otf_i, crc_err_i, par_err_i,
    input wire logic        recov_done_i, test_en_i, auto_pre_o, chop_o,
    input wire logic        burst_busy_o, alert_n_o, scan_mode_o,
    input wire logic [13:0] addr_i, opcode_o,
    input wire logic [3:0]  cmd_o
);
    logic       cke_q;
    logic       par_seen;
    logic [3:0] crc_win;
    wire  [2:0] rcw  = {ras_n_i, cas_n_i, we_n_i};
    wire        base = !cs_n_i && act_n_i && cke_q;
    wire        sel  = base && cke_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // mirror of previous cke and of pending alert causes
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cke_q    <= 1'b0;
            par_seen <= 1'b0;
            crc_win  <= 4'h0;
        end else begin
            cke_q    <= cke_i;
            par_seen <= par_err_i | (par_seen & ~recov_done_i);
            crc_win  <= crc_err_i ? 4'ha : crc_win - {3'h0, crc_win != 4'h0};
        end
    end
    AST_CRC_PULSE: assert property (crc_err_i && !par_err_i && !par_seen |=>
        (!alert_n_o)[*8] ##1 !alert_n_o ##1 !alert_n_o ##1 alert_n_o) else $error("crc pulse");
    AST_ALERT_REST: assert property (!par_seen && crc_win == 4'h0 |-> alert_n_o)
        else $error("alert low without cause");
    AST_PAR_HOLD: assert property (par_err_i || (par_seen && !recov_done_i) |=>
        !alert_n_o) else $error("parity alert released early");
    AST_SCAN: assert property ($changed(test_en_i) |=> scan_mode_o == $past(test_en_i))
        else $error("scan mode");
    AST_DESEL: assert property (cs_n_i && cke_i && cke_q |=> cmd_o == DCD_NONE)
        else $error("deselect decoded");
    AST_MRS: assert property (sel && rcw == 3'h0 |=>
        cmd_o == DCD_MRS && opcode_o == $past(addr_i)) else $error("mrs");
    AST_REF: assert property (base && rcw == 3'h1 |=>
        cmd_o == ($past(cke_i) ? DCD_REF : DCD_SRE)) else $error("refresh");
    AST_PRE: assert property (sel && rcw == 3'h2 |=>
        cmd_o == ($past(addr_i[10]) ? DCD_PREA : DCD_PRE)) else $error("precharge");
    AST_ACT: assert property (!cs_n_i && !act_n_i && sel == 1'b0 && cke_q && cke_i |=>
        cmd_o == DCD_ACT) else $error("activate");
    AST_WR: assert property (sel && rcw == 3'h4 && !burst_busy_o |=> cmd_o == DCD_WR &&
        auto_pre_o == $past(addr_i[10]) && chop_o == ($past(bl_otf_i) && !$past(addr_i[12])))
        else $error("write fields");
endmodule // dcd_decoder_chk

// ==== tb/dcd_ctrl_model.sv ====
/* controller model driving command and address pins.
   assumes the bench calls its tasks; pins change 1 ns after a rising edge. */
`timescale 1ns/1ps
module dcd_ctrl_model
    import dcd_pkg::*;
(
    input  wire logic   mclk_i,
    output logic        cke_o, cs_n_o,
    output logic [3:0]  cmdp_o,
    output logic [1:0]  bg_o, ba_o,
    output logic [13:0] addr_o
);
    initial {cke_o, cs_n_o, cmdp_o, bg_o, ba_o, addr_o} = {2'h3, 4'hf, 18'h0};
    // one command edge, then deselect with inverted command and address pins (bank pins kept) so stale values never pass
    task automatic issue(input dcd_cmd_t c, input logic [1:0] b, input logic [13:0] a);
        @(posedge mclk_i) #1;
        {cs_n_o, bg_o, ba_o, addr_o} = {1'b0, ~b, b, a};
        case (c)
            DCD_MRS: cmdp_o = 4'h8;
            DCD_REF: cmdp_o = 4'h9;
            DCD_SRE: {cmdp_o, cke_o} = 5'h12;
            DCD_PRE, DCD_PREA: cmdp_o = 4'ha;
            DCD_ACT: cmdp_o = 4'h5;
            default: cmdp_o = 4'hc;
        endcase
        @(posedge mclk_i) #1;
        {cs_n_o, cmdp_o, addr_o} = {1'b1, ~cmdp_o, ~addr_o};
    endtask
    // exit: cke rises while deselected
    task automatic srx();
        @(posedge mclk_i) #1 cke_o = 1'b1;
        @(posedge mclk_i) #1;
    endtask
endmodule // dcd_ctrl_model

// ==== tb/tb.sv ====
/* self-checking bench for dcd_decoder with the controller model.
   assumes dcd_pkg, the model and the checker are compiled first. */
`timescale 1ns/1ps
module tb;
    import dcd_pkg::*;
    logic mclk_i = 0, sys_rst_i = 1, bl_otf_i = 0, crc_err_i = 0, par_err_i = 0;
    logic recov_done_i = 0, test_en_i = 0, cke_i, cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i;
    logic auto_pre_o, chop_o, burst_busy_o, self_ref_o, scan_mode_o, alert_n_o;
    logic [1:0] bg_i, ba_i, bg_o, ba_o;
    logic [13:0] addr_i, opcode_o;
    logic [17:0] row_o;
    logic [9:0] col_o;
    logic [3:0] cmd_o;
    int error_cnt = 0, samples_checked = 0, n;
    always #2 mclk_i = ~mclk_i;
    dcd_ctrl_model u_dcd_ctrl_model (.mclk_i, .cke_o(cke_i), .cs_n_o(cs_n_i), .bg_o(bg_i),
        .cmdp_o({act_n_i, ras_n_i, cas_n_i, we_n_i}), .ba_o(ba_i), .addr_o(addr_i));
    dcd_decoder u_dcd_decoder (.mclk_i, .sys_rst_i, .cke_i, .cs_n_i, .act_n_i, .ras_n_i,
        .cas_n_i, .we_n_i, .bg_i, .ba_i, .addr_i, .bl_otf_i, .crc_err_i, .par_err_i,
        .recov_done_i, .test_en_i, .cmd_o, .bg_o, .ba_o, .row_o, .col_o, .opcode_o,
        .auto_pre_o, .chop_o, .burst_busy_o, .self_ref_o, .scan_mode_o, .alert_n_o);
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [13:0] a);
        for (n = 0; n < 8 && burst_busy_o !== 1'b0; n++) @(posedge mclk_i) #1;
        chk(burst_busy_o === 1'b0, "burst never ended");
        u_dcd_ctrl_model.issue(DCD_WR, 2'h1, a);
    endtask
    task automatic t_decode();
        u_dcd_ctrl_model.issue(DCD_MRS, 2'h2, 14'h1a5);
        chk(cmd_o === DCD_MRS && opcode_o === 14'h1a5 && bg_o === 2'h1, "mrs");
        u_dcd_ctrl_model.issue(DCD_REF, 2'h0, 14'h0);
        chk(cmd_o === DCD_REF, "ref");
        u_dcd_ctrl_model.issue(DCD_PRE, 2'h3, 14'h0);
        chk(cmd_o === DCD_PRE && ba_o === 2'h3, "pre");
        u_dcd_ctrl_model.issue(DCD_PREA, 2'h0, 14'h0400);
        chk(cmd_o === DCD_PREA, "prea");
        u_dcd_ctrl_model.issue(DCD_ACT, 2'h2, 14'h3c3);
        chk(cmd_o === DCD_ACT && row_o === {1'b0, 3'h5, 14'h3c3}, "act");
        $display("test decode done");
    endtask
    task automatic t_write();
        wr(14'h0405);
        chk(cmd_o === DCD_WR && {auto_pre_o, chop_o, col_o} === 12'h805, "wr fixed");
        u_dcd_ctrl_model.issue(DCD_WR, 2'h1, 14'h0000);
        chk(cmd_o === DCD_NONE && col_o === 10'h005, "write inside burst");
        bl_otf_i = 1;
        wr(14'h1003);
        chk({auto_pre_o, chop_o, col_o} === 12'h003, "wr otf full");
        wr(14'h0002);
        chk(chop_o === 1'b1 && burst_busy_o === 1'b1, "wr chop");
        $display("test write done");
    endtask
    task automatic t_sref();
        u_dcd_ctrl_model.issue(DCD_SRE, 2'h0, 14'h0);
        chk(cmd_o === DCD_SRE && self_ref_o === 1'b1, "sre");
        u_dcd_ctrl_model.srx();
        chk(cmd_o === DCD_SRX && self_ref_o === 1'b0, "srx");
        @(posedge mclk_i) #1 chk(cmd_o === DCD_NONE && self_ref_o === 1'b0, "sref left");
        $display("test self refresh done");
    endtask
    task automatic t_alert();
        crc_err_i = 1;
        @(posedge mclk_i) #1 crc_err_i = 0;
        for (n = 0; n < 20 && alert_n_o === 1'b0; n++) @(posedge mclk_i) #1;
        chk(n == DCD_CRC_PULSE_CYC, "crc pulse length");
        par_err_i = 1;
        @(posedge mclk_i) #1 par_err_i = 0;
        repeat (20) @(posedge mclk_i) #1;
        chk(alert_n_o === 1'b0, "parity hold");
        recov_done_i = 1;
        @(posedge mclk_i) #1 recov_done_i = 0;
        chk(alert_n_o === 1'b1, "alert rest");
        test_en_i = 1;
        @(posedge mclk_i) #1 chk(scan_mode_o === 1'b1, "scan on");
        $display("test alert done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk_i);
        #1 sys_rst_i = 0;
        chk(alert_n_o === 1'b1 && cmd_o === DCD_NONE && burst_busy_o === 1'b0, "reset");
        t_decode();
        t_write();
        t_sref();
        t_alert();
        report_and_stop();
    end
    initial begin
        #20000 error_cnt++;
        report_and_stop();
    end
endmodule // tb
bind dcd_decoder dcd_decoder_chk u_dcd_decoder_chk (.mclk_i, .sys_rst_i, .cke_i, .cs_n_i,
    .act_n_i, .ras_n_i, .cas_n_i, .we_n_i, .bl_otf_i, .crc_err_i, .par_err_i, .recov_done_i,
    .test_en_i, .auto_pre_o, .chop_o, .burst_busy_o, .alert_n_o, .scan_mode_o, .addr_i,
    .opcode_o, .cmd_o);
